// >>> core/rsc_pkg.sv
// Shared constants and types for the radio sleep controller
package rsc_pkg;
  // Clock and time base
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS = 1000000;
  localparam int CYC_PER_MS = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Brief data check and one-hop unicast allowance, in ms
  localparam int CHECK_TIME_MS = 2;
  localparam logic [24:0] CHECK_MS = 25'(CHECK_TIME_MS);
  localparam int ONE_HOP_TIME_MS = 20;
  localparam logic [21:0] ONE_HOP_MS = 22'(ONE_HOP_TIME_MS);
  // Sleep period unit (10 ms) and indirect hold factor (2.5 x 10 ms)
  localparam logic [24:0] SP_UNIT_MS = 25'h000000A;
  localparam logic [25:0] IND_HOLD_MS_PER_SP = 26'h0000019;
  // Register byte offsets
  localparam logic [7:0] OFF_MODE = 8'h00;
  localparam logic [7:0] OFF_OPT = 8'h04;
  localparam logic [7:0] OFF_PERIODS = 8'h08;
  localparam logic [7:0] OFF_SLEEP = 8'h0C;
  localparam logic [7:0] OFF_WAKE = 8'h10;
  localparam logic [7:0] OFF_HOSTDLY = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  localparam logic [7:0] OFF_OPSLEEP = 8'h1C;
  localparam logic [7:0] OFF_OPWAKE = 8'h20;
  localparam logic [7:0] OFF_SINCE = 8'h24;
  localparam logic [7:0] OFF_MISSED = 8'h28;
  localparam logic [7:0] OFF_IRQST = 8'h2C;
  localparam logic [7:0] OFF_IRQMASK = 8'h30;
  localparam logic [7:0] OFF_CTRL = 8'h34;
  // Reset values
  localparam logic [3:0] MODE_RST = 4'h0;
  localparam logic [8:0] OPT_RST = 9'h002;
  localparam logic [15:0] PERIODS_RST = 16'h0001;
  localparam logic [20:0] SP_RST = 21'h00012C;
  localparam logic [21:0] ST_RST = 22'h000BB8;
  localparam logic [15:0] WH_RST = 16'h0000;
  localparam logic [6:0] STATUS_RST = 7'h40;
  // Legal ranges
  localparam logic [20:0] SP_MAX = 21'h15F900;
  localparam logic [21:0] ST_MAX = 22'h36EE80;
  // Sleep mode codes
  localparam logic [3:0] MODE_NORMAL = 4'h0;
  localparam logic [3:0] MODE_PIN = 4'h1;
  localparam logic [3:0] MODE_ASYNC = 4'h4;
  localparam logic [3:0] MODE_ASYNC_PIN = 4'h5;
  localparam logic [3:0] MODE_SUPPORT = 4'h7;
  localparam logic [3:0] MODE_SYNC = 4'h8;
  // Option bit positions
  localparam int OPT_PREF_COORD = 0;
  localparam int OPT_NEVER_COORD = 1;
  localparam int OPT_STATUS_MSG = 2;
  localparam int OPT_NO_EARLY = 3;
  localparam int OPT_TYPE_EQ = 4;
  localparam int OPT_NO_REPEAT = 5;
  localparam int OPT_FULL_WAKE = 8;
  // Interrupt bit positions
  localparam int IRQ_WAKE = 0;
  localparam int IRQ_SLEEP = 1;
  localparam int IRQ_SYNC = 2;
  localparam int IRQ_MISSED = 3;
  localparam int IRQ_DROP = 4;
  localparam int IRQ_W = 5;
  // Sleep sequencer states
  typedef enum logic [3:0] {
    RSC_NORMAL = 4'b0001,
    RSC_SLEEP = 4'b0010,
    RSC_CHECK = 4'b0100,
    RSC_WAKE = 4'b1000
  } rsc_fsm_e;
endpackage : rsc_pkg

// >>> core/rsc_tick_if.sv
// Millisecond tick carried from the time base to the sequencer
`timescale 1ns/10ps
interface rsc_tick_if;
  logic tick_ms;
  modport src (output tick_ms);
  modport dst (input tick_ms);
endinterface : rsc_tick_if

// >>> core/rsc_ms_timebase.sv
// Free-running divider producing a one-cycle pulse every millisecond
`timescale 1ns/10ps
module rsc_ms_timebase #(
  parameter int CYC_PER_MS = rsc_pkg::CYC_PER_MS
) (
  input wire logic hclk, // System clock
  input wire logic hresetn, // Asynchronous reset, active low
  rsc_tick_if.src tick // Millisecond tick out
);
  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } rsc_tb_s;

  rsc_tb_s tb_ff;
  rsc_tb_s nxt_tb;

  // Count down one millisecond of clocks and pulse at wrap
  always_comb
  begin
    nxt_tb = tb_ff;
    nxt_tb.tick = 1'b0;
    if (tb_ff.cnt == 32'h00000000)
    begin
      nxt_tb.cnt = 32'(CYC_PER_MS - 1);
      nxt_tb.tick = 1'b1;
    end
    else
    begin
      nxt_tb.cnt = tb_ff.cnt - 32'h00000001;
    end
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      tb_ff <= '0;
    else
      tb_ff <= nxt_tb;
  end

  assign tick.tick_ms = tb_ff.tick;
endmodule : rsc_ms_timebase

// >>> core/rsc_sleep_ctrl.sv
// Sleep and wake sequencer with AHB-Lite register file
//
// The implementer's own choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/10ps
module rsc_sleep_ctrl #(
  parameter int CYC_PER_MS = rsc_pkg::CYC_PER_MS
) (
  input wire logic hclk, // System clock
  input wire logic hresetn, // Asynchronous reset, active low
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic [2:0] hsize, // Transfer size, word only
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  output logic hreadyout, // Slave ready
  output logic hresp, // Always OKAY
  output logic [31:0] hrdata, // Read data
  input wire logic sleep_request_pin, // Pin sleep request, high asks sleep
  input wire logic serial_rxd, // Serial receive line, idle high
  input wire logic radio_rx_valid, // Radio data received pulse
  input wire logic sync_msg_valid, // Sync message received pulse
  input wire logic [20:0] sync_sleep_time, // Network sleep time, 10 ms units
  input wire logic [21:0] sync_wake_time, // Network wake time, 1 ms units
  input wire logic nominate_req, // Coordinator nomination pulse
  input wire logic indirect_msg_stored, // Indirect message queued pulse
  output logic awake_out, // Awake indicator to host
  output logic host_tx_allow, // Serial output and samples allowed
  output logic indirect_discard, // Indirect message dropped pulse
  output logic irq // Level interrupt
);
  typedef struct packed {
    logic dp;
    logic dp_write;
    logic [7:0] dp_addr;
    logic rd_ready;
    logic [31:0] rdata;
    logic [3:0] mode;
    logic [8:0] opt;
    logic [15:0] periods;
    logic [20:0] sp;
    logic [21:0] st;
    logic [15:0] wh;
    logic ind_en;
    logic ever;
    logic this_cyc;
    logic changed;
    logic nom;
    logic deploy;
    logic [20:0] op_sp;
    logic [21:0] op_st;
    logic [15:0] since;
    logic [15:0] missed;
    logic [4:0] irq_st;
    logic [4:0] irq_mask;
    rsc_pkg::rsc_fsm_e fsm;
    logic [24:0] tmr;
    logic [15:0] nper;
    logic seen;
    logic [15:0] hdly;
    logic req_s1;
    logic req_s2;
    logic rxd_s1;
    logic rxd_s2;
    logic rxd_s3;
    logic ind_busy;
    logic [25:0] ind_tmr;
    logic ind_drop;
  } rsc_state_s;

  localparam rsc_state_s RST_STATE = '{
    mode: rsc_pkg::MODE_RST,
    opt: rsc_pkg::OPT_RST,
    periods: rsc_pkg::PERIODS_RST,
    sp: rsc_pkg::SP_RST,
    st: rsc_pkg::ST_RST,
    wh: rsc_pkg::WH_RST,
    deploy: rsc_pkg::STATUS_RST[6],
    op_sp: rsc_pkg::SP_RST,
    op_st: rsc_pkg::ST_RST,
    fsm: rsc_pkg::RSC_NORMAL,
    rxd_s1: 1'b1,
    rxd_s2: 1'b1,
    rxd_s3: 1'b1,
    default: '0
  };

  rsc_state_s s_ff;
  rsc_state_s nxt_s;
  rsc_tick_if tick_bus ();

  rsc_ms_timebase #(
    .CYC_PER_MS(CYC_PER_MS)
  ) u_timebase (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick(tick_bus.src)
  );

  logic tick;
  logic addr_ok;
  logic wr_now;
  logic rd_cap;
  logic [31:0] wd;
  logic serial_char;
  logic data_in;
  logic mode_ok;
  logic cyclic;
  logic stay_awake;
  logic coord;
  logic net_awake;
  logic tmr_done;
  logic [24:0] async_sleep_ms;
  logic [24:0] sync_sleep_ms;
  logic [24:0] sleep_ms;
  logic [21:0] min_wake;
  logic [21:0] eff_wake;
  logic [24:0] wake_entry;
  logic [6:0] status_word;
  logic [4:0] ev;
  logic chg_set;

  // Shared decode of bus, pins and timing figures
  always_comb
  begin
    tick = tick_bus.tick_ms;
    addr_ok = hsel && htrans[1] && hready;
    wr_now = s_ff.dp && s_ff.dp_write;
    rd_cap = s_ff.dp && !s_ff.dp_write && !s_ff.rd_ready;
    wd = hwdata;
    serial_char = s_ff.rxd_s3 && !s_ff.rxd_s2; // Start bit edge
    data_in = serial_char || radio_rx_valid;
    mode_ok = (wd[31:4] == 28'h0000000) && ((wd[3:0] == rsc_pkg::MODE_NORMAL) || (wd[3:0] == rsc_pkg::MODE_PIN) ||
      (wd[3:0] == rsc_pkg::MODE_ASYNC) || (wd[3:0] == rsc_pkg::MODE_ASYNC_PIN) ||
      (wd[3:0] == rsc_pkg::MODE_SUPPORT) || (wd[3:0] == rsc_pkg::MODE_SYNC));
    cyclic = (s_ff.mode == rsc_pkg::MODE_ASYNC) || (s_ff.mode == rsc_pkg::MODE_SYNC) ||
      ((s_ff.mode == rsc_pkg::MODE_ASYNC_PIN) && s_ff.req_s2);
    stay_awake = (s_ff.mode == rsc_pkg::MODE_NORMAL) || (s_ff.mode == rsc_pkg::MODE_SUPPORT) ||
      ((s_ff.mode == rsc_pkg::MODE_ASYNC_PIN) && !s_ff.req_s2);
    coord = (s_ff.mode == rsc_pkg::MODE_SYNC) && !s_ff.opt[rsc_pkg::OPT_NEVER_COORD] &&
      (s_ff.opt[rsc_pkg::OPT_PREF_COORD] || !s_ff.ever);
    net_awake = (s_ff.mode == rsc_pkg::MODE_SYNC) && (s_ff.fsm == rsc_pkg::RSC_WAKE);
    tmr_done = (s_ff.tmr == 25'h0000000);
    async_sleep_ms = 25'(s_ff.sp) * rsc_pkg::SP_UNIT_MS;
    // Sync sleep ends early by the host delay, never below one ms
    sync_sleep_ms = 25'(s_ff.op_sp) * rsc_pkg::SP_UNIT_MS;
    if (sync_sleep_ms > 25'(s_ff.wh))
      sync_sleep_ms = sync_sleep_ms - 25'(s_ff.wh);
    else
      sync_sleep_ms = 25'h0000001;
    sleep_ms = (s_ff.mode == rsc_pkg::MODE_SYNC) ? sync_sleep_ms : async_sleep_ms;
    // Wake window must cover host delay plus one hop
    min_wake = 22'(s_ff.wh) + rsc_pkg::ONE_HOP_MS;
    eff_wake = (s_ff.op_st < min_wake) ? min_wake : s_ff.op_st;
    // Async full wake lasts the wake time only if forced, else a check
    if (s_ff.mode == rsc_pkg::MODE_SYNC)
      wake_entry = 25'(eff_wake);
    else if (s_ff.opt[rsc_pkg::OPT_FULL_WAKE])
      wake_entry = 25'(s_ff.st);
    else
      wake_entry = rsc_pkg::CHECK_MS;
    status_word = {s_ff.deploy, s_ff.nom, s_ff.changed, s_ff.this_cyc, s_ff.ever, coord, net_awake};
  end

  // Next state of the whole block
  always_comb
  begin
    nxt_s = s_ff;
    ev = '0;
    chg_set = 1'b0;
    nxt_s.ind_drop = 1'b0;
    // Pin synchronisers
    nxt_s.req_s1 = sleep_request_pin;
    nxt_s.req_s2 = s_ff.req_s1;
    nxt_s.rxd_s1 = serial_rxd;
    nxt_s.rxd_s2 = s_ff.rxd_s1;
    nxt_s.rxd_s3 = s_ff.rxd_s2;
    // Bus data phase bookkeeping; reads take one wait state
    if (rd_cap)
    begin
      nxt_s.rd_ready = 1'b1;
      case (s_ff.dp_addr)
        rsc_pkg::OFF_MODE: nxt_s.rdata = 32'(s_ff.mode);
        rsc_pkg::OFF_OPT: nxt_s.rdata = 32'(s_ff.opt);
        rsc_pkg::OFF_PERIODS: nxt_s.rdata = 32'(s_ff.periods);
        rsc_pkg::OFF_SLEEP: nxt_s.rdata = 32'(s_ff.sp);
        rsc_pkg::OFF_WAKE: nxt_s.rdata = 32'(s_ff.st);
        rsc_pkg::OFF_HOSTDLY: nxt_s.rdata = 32'(s_ff.wh);
        rsc_pkg::OFF_STATUS: nxt_s.rdata = 32'(status_word);
        rsc_pkg::OFF_OPSLEEP: nxt_s.rdata = 32'(s_ff.op_sp);
        rsc_pkg::OFF_OPWAKE: nxt_s.rdata = 32'(s_ff.op_st);
        rsc_pkg::OFF_SINCE: nxt_s.rdata = 32'(s_ff.since);
        rsc_pkg::OFF_MISSED: nxt_s.rdata = 32'(s_ff.missed);
        rsc_pkg::OFF_IRQST: nxt_s.rdata = 32'(s_ff.irq_st);
        rsc_pkg::OFF_IRQMASK: nxt_s.rdata = 32'(s_ff.irq_mask);
        rsc_pkg::OFF_CTRL: nxt_s.rdata = 32'(s_ff.ind_en);
        default: nxt_s.rdata = 32'h00000000;
      endcase
      if (s_ff.dp_addr == rsc_pkg::OFF_IRQST)
        nxt_s.irq_st = '0;
    end
    if (wr_now || (s_ff.dp && s_ff.rd_ready))
    begin
      nxt_s.dp = 1'b0;
      nxt_s.rd_ready = 1'b0;
    end
    if (addr_ok)
    begin
      nxt_s.dp = 1'b1;
      nxt_s.dp_write = hwrite;
      nxt_s.dp_addr = haddr[7:0];
      nxt_s.rd_ready = 1'b0;
    end
    // Register writes, refusing illegal values
    if (wr_now)
    begin
      case (s_ff.dp_addr)
        rsc_pkg::OFF_MODE:
          if (mode_ok)
            nxt_s.mode = wd[3:0];
        rsc_pkg::OFF_OPT:
          if (!(wd[rsc_pkg::OPT_PREF_COORD] && wd[rsc_pkg::OPT_NEVER_COORD]))
          begin
            nxt_s.opt = {wd[8], 2'b00, wd[5:0]};
            chg_set = coord;
          end
        rsc_pkg::OFF_PERIODS:
          if (wd[15:0] != 16'h0000)
            nxt_s.periods = wd[15:0];
        rsc_pkg::OFF_SLEEP:
          if ((wd[31:21] == 11'h000) && (wd[20:0] != 21'h000000) && (wd[20:0] <= rsc_pkg::SP_MAX))
          begin
            nxt_s.sp = wd[20:0];
            chg_set = coord;
          end
        rsc_pkg::OFF_WAKE:
          if ((wd[31:22] == 10'h000) && (wd[21:0] != 22'h000000) && (wd[21:0] <= rsc_pkg::ST_MAX))
          begin
            nxt_s.st = wd[21:0];
            chg_set = coord;
          end
        rsc_pkg::OFF_HOSTDLY: nxt_s.wh = wd[15:0];
        rsc_pkg::OFF_MISSED:
          if (wd == 32'h00000000)
            nxt_s.missed = 16'h0000;
        rsc_pkg::OFF_IRQMASK: nxt_s.irq_mask = wd[4:0];
        rsc_pkg::OFF_CTRL: nxt_s.ind_en = wd[0];
        default: nxt_s.ind_en = nxt_s.ind_en;
      endcase
    end
    // Sync messages adopt the network timing
    if (sync_msg_valid)
    begin
      nxt_s.op_sp = sync_sleep_time;
      nxt_s.op_st = sync_wake_time;
      nxt_s.ever = 1'b1;
      nxt_s.this_cyc = 1'b1;
      nxt_s.deploy = 1'b0;
      nxt_s.since = 16'h0000;
      ev[rsc_pkg::IRQ_SYNC] = 1'b1;
    end
    if (nominate_req)
      nxt_s.nom = 1'b1;
    // Timers count milliseconds
    if (tick && !tmr_done)
      nxt_s.tmr = s_ff.tmr - 25'h0000001;
    if (tick && (s_ff.hdly != 16'h0000))
      nxt_s.hdly = s_ff.hdly - 16'h0001;
    // Sleep sequencer
    case (s_ff.fsm)
      rsc_pkg::RSC_NORMAL:
        if ((s_ff.mode == rsc_pkg::MODE_PIN) && s_ff.req_s2)
        begin
          nxt_s.fsm = rsc_pkg::RSC_SLEEP;
          ev[rsc_pkg::IRQ_SLEEP] = 1'b1;
        end
        else if (cyclic)
        begin
          nxt_s.fsm = rsc_pkg::RSC_SLEEP;
          nxt_s.tmr = sleep_ms;
          ev[rsc_pkg::IRQ_SLEEP] = 1'b1;
        end
      rsc_pkg::RSC_SLEEP:
        if (stay_awake || ((s_ff.mode == rsc_pkg::MODE_PIN) && !s_ff.req_s2))
        begin
          nxt_s.fsm = rsc_pkg::RSC_NORMAL;
          nxt_s.hdly = s_ff.wh;
          ev[rsc_pkg::IRQ_WAKE] = 1'b1;
        end
        else if (cyclic && tmr_done)
        begin
          if ((s_ff.mode == rsc_pkg::MODE_SYNC) || (s_ff.nper + 16'h0001 >= s_ff.periods))
          begin
            nxt_s.fsm = rsc_pkg::RSC_WAKE;
            nxt_s.tmr = wake_entry;
            nxt_s.nper = 16'h0000;
            nxt_s.seen = 1'b0;
            nxt_s.hdly = s_ff.wh;
            ev[rsc_pkg::IRQ_WAKE] = 1'b1;
            if (s_ff.mode == rsc_pkg::MODE_SYNC)
            begin
              nxt_s.this_cyc = sync_msg_valid;
              if (coord)
              begin
                nxt_s.changed = 1'b0;
                nxt_s.nom = nominate_req;
              end
            end
          end
          else
          begin
            nxt_s.fsm = rsc_pkg::RSC_CHECK;
            nxt_s.tmr = rsc_pkg::CHECK_MS;
            nxt_s.nper = s_ff.nper + 16'h0001;
          end
        end
      rsc_pkg::RSC_CHECK:
        if (stay_awake || data_in)
        begin
          nxt_s.fsm = stay_awake ? rsc_pkg::RSC_NORMAL : rsc_pkg::RSC_WAKE;
          nxt_s.tmr = 25'(s_ff.st);
          nxt_s.seen = 1'b1;
          nxt_s.hdly = s_ff.wh;
          ev[rsc_pkg::IRQ_WAKE] = 1'b1;
        end
        else if (tmr_done)
        begin
          nxt_s.fsm = rsc_pkg::RSC_SLEEP;
          nxt_s.tmr = sleep_ms;
        end
      rsc_pkg::RSC_WAKE:
        if (stay_awake)
          nxt_s.fsm = rsc_pkg::RSC_NORMAL;
        else if ((s_ff.mode != rsc_pkg::MODE_SYNC) && data_in)
        begin
          nxt_s.tmr = 25'(s_ff.st);
          nxt_s.seen = 1'b1;
        end
        else if (tmr_done || ((s_ff.mode == rsc_pkg::MODE_PIN) && s_ff.req_s2))
        begin
          nxt_s.fsm = rsc_pkg::RSC_SLEEP;
          nxt_s.tmr = sleep_ms;
          ev[rsc_pkg::IRQ_SLEEP] = 1'b1;
          if (s_ff.mode == rsc_pkg::MODE_SYNC)
          begin
            if (s_ff.since != 16'hFFFF)
              nxt_s.since = nxt_s.since + 16'h0001;
            if (!s_ff.this_cyc && !sync_msg_valid)
            begin
              ev[rsc_pkg::IRQ_MISSED] = 1'b1;
              if (nxt_s.missed != 16'hFFFF)
                nxt_s.missed = nxt_s.missed + 16'h0001;
            end
          end
        end
      default:
      begin
        nxt_s.fsm = rsc_pkg::RSC_NORMAL;
        nxt_s.tmr = '0;
      end
    endcase
    // A received character cuts the host delay short
    if (serial_char)
      nxt_s.hdly = 16'h0000;
    // Indirect message hold timer, armed only while the control register enable bit is set
    if (s_ff.ind_busy && tick)
    begin
      if (s_ff.ind_tmr <= 26'h0000001)
      begin
        nxt_s.ind_busy = 1'b0;
        nxt_s.ind_drop = 1'b1;
        ev[rsc_pkg::IRQ_DROP] = 1'b1;
      end
      else
        nxt_s.ind_tmr = s_ff.ind_tmr - 26'h0000001;
    end
    if (indirect_msg_stored && s_ff.ind_en && (s_ff.sp != 21'h000000))
    begin
      nxt_s.ind_busy = 1'b1;
      nxt_s.ind_tmr = 26'(s_ff.sp) * rsc_pkg::IND_HOLD_MS_PER_SP;
    end
    // Settings change made as coordinator beats the wake-start clear
    if (chg_set)
      nxt_s.changed = 1'b1;
    // Operating times follow local settings until synchronised
    if (!nxt_s.ever)
    begin
      nxt_s.op_sp = nxt_s.sp;
      nxt_s.op_st = nxt_s.st;
    end
    // Sticky interrupt status; new events win over read clear
    nxt_s.irq_st = nxt_s.irq_st | ev;
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      s_ff <= RST_STATE;
    else
      s_ff <= nxt_s;
  end

  // Outputs decoded from registered state
  assign hreadyout = !(s_ff.dp && !s_ff.dp_write && !s_ff.rd_ready);
  assign hresp = 1'b0;
  assign hrdata = s_ff.rdata;
  assign awake_out = (s_ff.fsm == rsc_pkg::RSC_NORMAL) || (s_ff.fsm == rsc_pkg::RSC_WAKE);
  assign host_tx_allow = awake_out && (s_ff.hdly == 16'h0000);
  assign indirect_discard = s_ff.ind_drop;
  assign irq = |(s_ff.irq_st & s_ff.irq_mask);
endmodule : rsc_sleep_ctrl

// >>> testbench/rsc_sleep_ctrl_asserts.sv
// Port-level assertions for the sleep controller
`timescale 1ns/10ps
module rsc_sleep_ctrl_asserts #(
  parameter int CYC_PER_MS = 10
) (
  input wire logic hclk, // Clock
  input wire logic hresetn, // Reset
  input wire logic hsel, // Select
  input wire logic [1:0] htrans, // Transfer
  input wire logic hwrite, // Write
  input wire logic hready, // Bus ready
  input wire logic hreadyout, // Slave ready
  input wire logic hresp, // Response
  input wire logic [31:0] hrdata, // Read data
  input wire logic serial_rxd, // Serial line
  input wire logic awake_out, // Awake
  input wire logic host_tx_allow, // Host gate
  input wire logic indirect_discard, // Drop pulse
  input wire logic irq // Interrupt
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // Accepted address phase
  wire logic req = hsel && htrans[1] && hready;
  // Bus timing
  read_wait_a: assert property (req && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  write_fast_a: assert property (req && hwrite |=> hreadyout)
    else $error("write wait state seen");
  rdata_hold_a: assert property (hreadyout |=> $stable(hrdata))
    else $error("read data moved");
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("error response");
  // Indicator and host gate
  tx_gate_a: assert property (host_tx_allow |-> awake_out)
    else $error("host output while asleep");
  serial_stop_a: assert property ($fell(serial_rxd) |-> ##[1:6] (host_tx_allow || !awake_out))
    else $error("host delay not cut");
  reset_wake_a: assert property ($rose(hresetn) |-> awake_out && host_tx_allow && !irq)
    else $error("bad state after reset");
  discard_gap_a: assert property (indirect_discard |=> !indirect_discard [*8])
    else $error("discard pulse too long");
  // Main scenarios
  wake_c: cover property ($rose(awake_out));
  drop_c: cover property (indirect_discard);
  irq_c: cover property ($rose(irq));
endmodule : rsc_sleep_ctrl_asserts

// >>> testbench/rsc_host_model.sv
// Host processor and radio network stand-in
`timescale 1ns/10ps
module rsc_host_model (
  input wire logic hclk, // Clock
  output logic serial_rxd, // Serial line, idles high
  output logic radio_rx_valid, // Radio data pulse
  output logic indirect_msg_stored, // Store pulse
  output logic nominate_req, // Nomination pulse
  output logic sync_msg_valid, // Sync pulse
  output logic [20:0] sync_sleep_time, // Net sleep time
  output logic [21:0] sync_wake_time // Net wake time
);
  // Idle levels
  initial
  begin
    serial_rxd = 1'b1;
    {nominate_req, indirect_msg_stored, radio_rx_valid, sync_msg_valid} = 4'h0;
    sync_sleep_time = 21'h0;
    sync_wake_time = 22'h0;
  end
  // One character; its start bit cuts the host delay short
  task chr();
    serial_rxd <= 1'b0;
    repeat (8) @(posedge hclk);
    serial_rxd <= 1'b1;
    @(posedge hclk);
  endtask : chr
  // One-cycle event: 0 radio data, 1 indirect store, 2 nomination
  task pulse(input int k);
    {nominate_req, indirect_msg_stored, radio_rx_valid} <= 3'(3'h1 << k);
    @(posedge hclk);
    {nominate_req, indirect_msg_stored, radio_rx_valid} <= 3'h0;
  endtask : pulse
  // Sync message; its fields do not hold after the pulse
  task sync(input logic [20:0] s, input logic [21:0] w);
    sync_msg_valid <= 1'b1;
    sync_sleep_time <= s;
    sync_wake_time <= w;
    @(posedge hclk);
    sync_msg_valid <= 1'b0;
    sync_sleep_time <= ~s;
    sync_wake_time <= ~w;
  endtask : sync
endmodule : rsc_host_model

// >>> testbench/test_rsc_sleep_ctrl.sv
// Self-checking bench for the sleep controller
`timescale 1ns/10ps
module test_rsc_sleep_ctrl;
  localparam int CPM = 10;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic sleep_req = 1'b0;
  logic [31:0] rd;
  logic [31:0] hrdata;
  logic hreadyout, hresp, awake_out, host_tx_allow, indirect_discard, irq, serial_rxd, radio_rx_valid;
  logic sync_msg_valid, nominate_req, indirect_msg_stored;
  logic [20:0] sync_sleep_time;
  logic [21:0] sync_wake_time;
  int num_errors = 0;
  int tests_run = 0;
  // Clock
  always #5 hclk = ~hclk;
  // Design and its far side
  rsc_sleep_ctrl #(.CYC_PER_MS(CPM)) uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .sleep_request_pin(sleep_req), .serial_rxd, .radio_rx_valid,
    .sync_msg_valid, .sync_sleep_time, .sync_wake_time, .nominate_req, .indirect_msg_stored, .awake_out,
    .host_tx_allow, .indirect_discard, .irq);
  rsc_host_model host (.hclk, .serial_rxd, .radio_rx_valid, .indirect_msg_stored, .nominate_req,
    .sync_msg_valid, .sync_sleep_time, .sync_wake_time);
  // Compare and count
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  // A cycle count inside its window
  task rng(input int n, input int lo, input int hi);
    chk(32'(n), (n >= lo && n <= hi) ? 32'(n) : 32'(lo));
  endtask : rng
  // One single transfer; read data left in rd
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  // Cycles until the indicator shows v
  task wt(input logic v, output int n);
    n = 0;
    while (awake_out !== v)
    begin
      @(posedge hclk);
      n++;
    end
  endtask : wt
  // Reset values, then one unmapped word
  task t_reset();
    logic [31:0] e [15];
    e = '{32'h0, 32'h2, 32'h1, 32'h12C, 32'hBB8, 32'h0, 32'h40, 32'h12C, 32'hBB8, 32'h0, 32'h0, 32'h0,
      32'h0, 32'h0, 32'h0};
    for (int i = 0; i < 15; i++)
    begin
      bus(1'b0, 8'(4 * i), 32'h0);
      chk(rd, e[i]);
    end
  endtask : t_reset
  // Mode codes 0 to 9, legal ones kept
  task t_modes();
    logic [31:0] p;
    p = 32'h0;
    for (int c = 0; c < 10; c++)
    begin
      bus(1'b1, 8'h00, 32'(c));
      if (c inside {0, 1, 4, 5, 7, 8})
        p = 32'(c);
      bus(1'b0, 8'h00, 32'h0);
      chk(rd, p);
    end
    // Pin sleep follows the synchronised request line
    bus(1'b1, 8'h00, 32'h1);
    sleep_req <= 1'b1;
    repeat (4) @(posedge hclk);
    chk(32'(awake_out), 32'h0);
    sleep_req <= 1'b0;
    repeat (4) @(posedge hclk);
    chk(32'(awake_out), 32'h1);
    bus(1'b1, 8'h00, 32'h0);
  endtask : t_modes
  // Refused and accepted field writes
  task t_refuse();
    logic [7:0] a [8];
    logic [31:0] d [8];
    logic [31:0] e [8];
    a = '{8'h04, 8'h04, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h28, 8'h04};
    d = '{32'h3, 32'h1FF, 32'h1FD, 32'h0, 32'h0, 32'h0, 32'h5, 32'h100};
    e = '{32'h2, 32'h2, 32'h13D, 32'h1, 32'h12C, 32'hBB8, 32'h0, 32'h100};
    for (int i = 0; i < 8; i++)
    begin
      bus(1'b1, a[i], d[i]);
      bus(1'b0, a[i], 32'h0);
      chk(rd, e[i]);
    end
  endtask : t_refuse
  // Async cycles: wake every second period, host delay, interrupt, data in a check
  task t_async();
    int n1, n2;
    logic s;
    bus(1'b1, 8'h30, 32'h1);
    bus(1'b1, 8'h08, 32'h2);
    bus(1'b1, 8'h0C, 32'h1);
    bus(1'b1, 8'h10, 32'h3);
    bus(1'b1, 8'h14, 32'h5);
    bus(1'b1, 8'h00, 32'h4);
    wt(1'b0, n1);
    wt(1'b1, n1);
    wt(1'b0, n1);
    wt(1'b1, n2);
    rng(n1, 2 * CPM, 4 * CPM);
    rng(n2, 19 * CPM, 25 * CPM);
    repeat (3) @(posedge hclk);
    chk(32'(irq), 32'h1);
    chk(32'(host_tx_allow), 32'h0);
    host.chr();
    chk(32'(host_tx_allow), 32'h1);
    bus(1'b0, 8'h2C, 32'h0);
    chk(32'(rd[0]), 32'h1);
    chk(32'(irq), 32'h0);
    wt(1'b0, n1);
    s = 1'b0;
    repeat (8 * CPM + 5) @(posedge hclk);
    for (int k = 0; k < 10; k++)
    begin
      host.pulse(0);
      repeat (4) @(posedge hclk);
      s = s | awake_out;
    end
    chk(32'(s), 32'h1);
  endtask : t_async
  // Sync cycles: operating times, status, shortened sleep, raised wake, counters
  task t_sync();
    int n1, n2;
    bus(1'b1, 8'h00, 32'h0);
    bus(1'b1, 8'h30, 32'h0);
    bus(1'b1, 8'h14, 32'h5);
    bus(1'b1, 8'h10, 32'h1);
    bus(1'b1, 8'h00, 32'h8);
    host.sync(21'h2, 22'h2);
    host.pulse(2);
    bus(1'b0, 8'h1C, 32'h0);
    chk(rd, 32'h2);
    bus(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h2);
    bus(1'b0, 8'h18, 32'h0);
    chk(32'({rd[6], rd[5], rd[2]}), 32'h3);
    wt(1'b1, n1);
    wt(1'b0, n1);
    wt(1'b1, n2);
    rng(n1, 23 * CPM, 27 * CPM);
    rng(n2, 13 * CPM, 17 * CPM);
    wt(1'b0, n1);
    bus(1'b0, 8'h24, 32'h0);
    chk(rd, 32'h2);
    bus(1'b0, 8'h28, 32'h0);
    chk(32'(rd inside {[1:2]}), 32'h1);
    bus(1'b1, 8'h28, 32'h0);
    bus(1'b0, 8'h28, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, 8'h00, 32'h0);
  endtask : t_sync
  // Indirect message dropped after two and a half sleep periods
  task t_ind();
    int n;
    bus(1'b1, 8'h34, 32'h1);
    host.pulse(1);
    n = 0;
    while (indirect_discard !== 1'b1)
    begin
      @(posedge hclk);
      n++;
    end
    rng(n, 23 * CPM, 27 * CPM);
  endtask : t_ind
  // Verdict
  task wrap_up();
    $display("mismatches %0d, comparisons %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up
  // Main sequence
  initial
  begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_modes();
    t_refuse();
    t_async();
    t_sync();
    t_ind();
    wrap_up();
  end
  // Watchdog, several times the expected run
  initial
  begin
    #100000;
    num_errors++;
    wrap_up();
  end
endmodule : test_rsc_sleep_ctrl
bind rsc_sleep_ctrl rsc_sleep_ctrl_asserts #(.CYC_PER_MS(CYC_PER_MS)) chk_i (.hclk, .hresetn, .hsel, .htrans,
  .hwrite, .hready, .hreadyout, .hresp, .hrdata, .serial_rxd, .awake_out, .host_tx_allow, .indirect_discard, .irq);
